// ===== sar_core_model.sv
// Purpose: stand-in for the analog core behind the converter
// Assumes: code held steady through a conversion
// Notes: outside a conversion the data is inverted so stale reads show
`timescale 1ns/1ns
module sar_core_model
(
    input wire logic sar_convert,
    input wire logic sar_powered,
    input wire logic [11:0] code,
    output logic [11:0] sar_data
);
    // true code only while powered and converting
    assign sar_data = (sar_convert && sar_powered) ? code : ~code;
endmodule // sar_core_model

// ===== sar_ctrl_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: only the upper limit low byte address is fixed; the rest are free
package sar_ctrl_pkg;
    localparam int addr_w = 8;
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] result_high_addr = 8'h04;
    localparam logic [7:0] result_low_addr = 8'h08;
    localparam logic [7:0] cfg_addr = 8'h0C;
    localparam logic [7:0] irq_status_addr = 8'h10;
    localparam logic [7:0] irq_clear_addr = 8'h14;
    localparam logic [7:0] irq_enable_addr = 8'h18;
    localparam logic [7:0] upper_limit_high_addr = 8'hC0;
    localparam logic [7:0] upper_limit_low_addr = 8'hC4;
    localparam logic [7:0] lower_limit_high_addr = 8'hC8;
    localparam logic [7:0] lower_limit_low_addr = 8'hCC;
    // control register bit positions
    localparam int ctrl_enable_bit = 7;
    localparam int ctrl_track_bit = 6;
    localparam int ctrl_done_bit = 5;
    localparam int ctrl_busy_bit = 4;
    localparam int ctrl_src_lsb = 2;
    localparam int ctrl_window_bit = 1;
    localparam int ctrl_justify_bit = 0;
    // config register fields
    localparam int cfg_diff_bit = 7;
    localparam int cfg_div_w = 5;
    // interrupt bit positions
    localparam int irq_done_bit = 0;
    localparam int irq_window_bit = 1;
    localparam int irq_w = 2;
    // reset values
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] upper_limit_high_reset = 8'hFF;
    localparam logic [7:0] upper_limit_low_reset = 8'hFF;
    localparam logic [7:0] lower_limit_reset = 8'h00;
    localparam logic [7:0] cfg_reset = 8'h00;
    // timing in converter clocks
    localparam int track_sar_clks = 3;
    localparam int conv_sar_clks = 16;
    localparam int sar_cnt_w = 4;
    localparam int result_w = 12;
    typedef enum logic [1:0]
    {
        src_software = 2'b00,
        src_timer3 = 2'b01,
        src_pin = 2'b10,
        src_timer2 = 2'b11
    } start_src_t;
endpackage

// ===== sar_result_format_window_detect.sv
// Purpose: converter control, result packing and window detection with apb access
// Assumes: triggers and external start pin synchronous to pclk
// Notes: unmapped addresses read zero and answer with pslverr
`timescale 1ns/1ns
module sar_result_format_window_detect
    import sar_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [addr_w-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer2_overflow,
    input wire logic timer3_overflow,
    input wire logic external_start_pin,
    input wire logic [result_w-1:0] sar_data,
    output logic sar_track,
    output logic sar_convert,
    output logic sar_powered,
    output logic irq
);
    typedef struct packed
    {
        logic enable;
        logic track_mode_select;
        logic conversion_done_flag;
        logic [1:0] start_source_select;
        logic window_compare_flag;
        logic left_justify_select;
        logic [7:0] input_pairing_config;
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
        logic [7:0] upper_limit_high_byte;
        logic [7:0] upper_limit_low_byte;
        logic [7:0] lower_limit_high_byte;
        logic [7:0] lower_limit_low_byte;
        logic [irq_w-1:0] irq_enable;
        logic pin_prev;
        logic [31:0] rdata;
        logic slverr;
    } ctrl_reg_t;

    ctrl_reg_t q;
    ctrl_reg_t d;
    sar_seq_if sif();

    logic wr_en;
    logic setup;
    logic pin_rise;
    logic trigger;
    logic diff;
    logic [result_w-1:0] r;
    logic [15:0] word;
    logic [15:0] upper;
    logic [15:0] lower;
    logic above;
    logic below;
    logic hit;
    logic [7:0] ctrl_view;
    logic [irq_w-1:0] status;

    sar_sequencer u_seq
    (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // zero wait state: data is latched in setup, so the access phase can finish at once
    assign pready = psel & penable;
    assign prdata = q.rdata;
    assign pslverr = q.slverr;
    assign wr_en = psel & penable & pwrite;
    assign setup = psel & ~penable;

    assign pin_rise = external_start_pin & ~q.pin_prev;
    always_comb
    begin
        case (start_src_t'(q.start_source_select))
            src_software:
            begin
                trigger = wr_en && paddr == ctrl_addr && pwdata[ctrl_busy_bit];
            end
            src_timer3:
            begin
                trigger = timer3_overflow;
            end
            src_pin:
            begin
                trigger = pin_rise;
            end
            default:
            begin
                trigger = timer2_overflow;
            end
        endcase
    end

    // a trigger that arrives mid-conversion is dropped, the analog core cannot restart
    assign sif.start = q.enable & trigger & ~sif.busy;
    assign sif.track_first = q.track_mode_select
        && (start_src_t'(q.start_source_select) != src_pin);
    assign sif.clk_div = q.input_pairing_config[cfg_div_w-1:0];
    assign sif.sar_data = sar_data;

    assign sar_powered = q.enable;
    assign sar_convert = sif.converting;
    // pin mode in low-power tracking: track while the pin is low
    assign sar_track = q.enable & (sif.tracking | (~sif.busy & (~q.track_mode_select
        | (start_src_t'(q.start_source_select) == src_pin & ~external_start_pin))));

    // packing of the fresh result
    assign diff = q.input_pairing_config[cfg_diff_bit];
    assign r = sif.result;
    always_comb
    begin
        if (q.left_justify_select)
        begin
            word = {r, 4'h0};
        end
        else
        begin
            word = {diff ? {4{r[result_w-1]}} : 4'h0, r};
        end
    end

    assign upper = {q.upper_limit_high_byte, q.upper_limit_low_byte};
    assign lower = {q.lower_limit_high_byte, q.lower_limit_low_byte};
    assign above = diff ? ($signed(word) > $signed(upper)) : (word > upper);
    assign below = diff ? ($signed(word) < $signed(lower)) : (word < lower);
    // lower above upper: inside window; otherwise outside
    assign hit = (diff ? ($signed(lower) > $signed(upper)) : (lower > upper))
        ? (above & below) : (above | below);

    assign ctrl_view = {q.enable, q.track_mode_select, q.conversion_done_flag, sif.busy,
        q.start_source_select, q.window_compare_flag, q.left_justify_select};
    assign status = {q.window_compare_flag, q.conversion_done_flag};
    assign irq = |(status & q.irq_enable);

    always_comb
    begin
        d = q;
        d.pin_prev = external_start_pin;
        if (setup)
        begin
            d.slverr = 1'b0;
            d.rdata = '0;
            case (paddr)
                ctrl_addr:
                begin
                    d.rdata[7:0] = ctrl_view;
                end
                result_high_addr:
                begin
                    d.rdata[7:0] = q.result_high_byte;
                end
                result_low_addr:
                begin
                    d.rdata[7:0] = q.result_low_byte;
                end
                cfg_addr:
                begin
                    d.rdata[7:0] = q.input_pairing_config;
                end
                irq_status_addr:
                begin
                    d.rdata[irq_w-1:0] = status;
                end
                irq_clear_addr:
                begin
                    d.rdata = '0;
                end
                irq_enable_addr:
                begin
                    d.rdata[irq_w-1:0] = q.irq_enable;
                end
                upper_limit_high_addr:
                begin
                    d.rdata[7:0] = q.upper_limit_high_byte;
                end
                upper_limit_low_addr:
                begin
                    d.rdata[7:0] = q.upper_limit_low_byte;
                end
                lower_limit_high_addr:
                begin
                    d.rdata[7:0] = q.lower_limit_high_byte;
                end
                lower_limit_low_addr:
                begin
                    d.rdata[7:0] = q.lower_limit_low_byte;
                end
                default:
                begin
                    d.slverr = 1'b1;
                end
            endcase
        end
        if (wr_en)
        begin
            case (paddr)
                ctrl_addr:
                begin
                    d.enable = pwdata[ctrl_enable_bit];
                    d.track_mode_select = pwdata[ctrl_track_bit];
                    d.start_source_select = pwdata[ctrl_src_lsb +: 2];
                    d.left_justify_select = pwdata[ctrl_justify_bit];
                    // flags clear on writing zero, writing one leaves them alone
                    if (!pwdata[ctrl_done_bit])
                    begin
                        d.conversion_done_flag = 1'b0;
                    end
                    if (!pwdata[ctrl_window_bit])
                    begin
                        d.window_compare_flag = 1'b0;
                    end
                end
                cfg_addr:
                begin
                    d.input_pairing_config = pwdata[7:0];
                end
                irq_clear_addr:
                begin
                    if (pwdata[irq_done_bit])
                    begin
                        d.conversion_done_flag = 1'b0;
                    end
                    if (pwdata[irq_window_bit])
                    begin
                        d.window_compare_flag = 1'b0;
                    end
                end
                irq_enable_addr:
                begin
                    d.irq_enable = pwdata[irq_w-1:0];
                end
                upper_limit_high_addr:
                begin
                    d.upper_limit_high_byte = pwdata[7:0];
                end
                upper_limit_low_addr:
                begin
                    d.upper_limit_low_byte = pwdata[7:0];
                end
                lower_limit_high_addr:
                begin
                    d.lower_limit_high_byte = pwdata[7:0];
                end
                lower_limit_low_addr:
                begin
                    d.lower_limit_low_byte = pwdata[7:0];
                end
                default:
                begin
                end
            endcase
        end
        // hardware set comes last so it beats a clear in the same cycle
        if (sif.done)
        begin
            d.result_high_byte = word[15:8];
            d.result_low_byte = word[7:0];
            d.conversion_done_flag = 1'b1;
            if (hit)
            begin
                d.window_compare_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '{enable: ctrl_reset[ctrl_enable_bit],
                track_mode_select: ctrl_reset[ctrl_track_bit],
                conversion_done_flag: ctrl_reset[ctrl_done_bit],
                start_source_select: ctrl_reset[ctrl_src_lsb +: 2],
                window_compare_flag: ctrl_reset[ctrl_window_bit],
                left_justify_select: ctrl_reset[ctrl_justify_bit],
                input_pairing_config: cfg_reset,
                result_high_byte: 8'h00,
                result_low_byte: 8'h00,
                upper_limit_high_byte: upper_limit_high_reset,
                upper_limit_low_byte: upper_limit_low_reset,
                lower_limit_high_byte: lower_limit_reset,
                lower_limit_low_byte: lower_limit_reset,
                irq_enable: '0,
                pin_prev: 1'b0,
                rdata: 32'h0000_0000,
                slverr: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end
endmodule // sar_result_format_window_detect

// ===== sar_result_format_window_detect_asserts.sv
// Purpose: port-level checks of the converter control block
// Assumes: timing checks only with divider zero
// Notes: shadows of control, config and enable writes steer the checks
`timescale 1ns/1ns
module sar_window_asserts
    import sar_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [addr_w-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic timer3_overflow,
    input wire logic sar_track,
    input wire logic sar_convert,
    input wire logic sar_powered,
    input wire logic irq
);
    logic wr;
    logic [7:0] ctl_q;
    logic [cfg_div_w-1:0] div_q;
    logic [irq_w-1:0] en_q;
    logic gtl_w_q;
    assign wr = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_q <= ctrl_reset;
            div_q <= '0;
            en_q <= '0;
            gtl_w_q <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == ctrl_addr)
                ctl_q <= pwdata[7:0];
            if (paddr == cfg_addr)
                div_q <= pwdata[cfg_div_w-1:0];
            if (paddr == irq_enable_addr)
                en_q <= pwdata[irq_w-1:0];
            if (paddr == upper_limit_low_addr)
                gtl_w_q <= 1'b1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_sw_start;
        wr && paddr == ctrl_addr && pwdata[7:2] == 6'b100100 && sar_powered && !sar_convert
            && !ctl_q[6] && ctl_q[3:2] == 2'b00 |=> sar_convert;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start ignored");
    property p_t3_track;
        div_q == 0 && ctl_q[6] && ctl_q[3:2] == 2'b01 && sar_powered && timer3_overflow
            && !sar_convert && !sar_track |=> sar_track[*3] ##1 sar_convert;
    endproperty
    a_t3_track: assert property (p_t3_track)
        else $error("tracking interval wrong");
    property p_conv_len;
        $rose(sar_convert) && div_q == 0 |-> sar_convert[*8] ##1 sar_convert[*8] ##1 !sar_convert;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");
    property p_enable;
        $rose(sar_convert) |-> sar_powered;
    endproperty
    a_enable: assert property (p_enable)
        else $error("conversion while disabled");
    property p_done_irq;
        $fell(sar_convert) && en_q[irq_done_bit] |=> irq;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("no interrupt at end of conversion");
    property p_sticky;
        irq && !wr |=> irq;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("interrupt dropped without a clear");
    property p_irq_off;
        en_q == '0 && $past(en_q) == '0 |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("masked interrupt raised");
    property p_gtl_reset;
        psel && penable && !pwrite && paddr == upper_limit_low_addr && !gtl_w_q
            |-> prdata[7:0] == 8'hFF;
    endproperty
    a_gtl_reset: assert property (p_gtl_reset)
        else $error("upper limit low byte reset value wrong");
endmodule // sar_window_asserts

bind sar_result_format_window_detect sar_window_asserts sar_window_asserts_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .timer3_overflow, .sar_track,
    .sar_convert, .sar_powered, .irq);

// ===== sar_result_format_window_detect_test.sv
// Purpose: self-checking bench of the converter control block
// Assumes: apb master loops on pready, divider zero except one row
// Notes: table rows first, then reset, window and interrupt cases
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module sar_result_format_window_detect_test
    import sar_ctrl_pkg::*;
;
    typedef struct packed
    {
        logic [7:0] cfg;
        logic [7:0] ctl;
        logic [11:0] code;
        logic [7:0] hi;
        logic [7:0] lo;
    } row_t;
    // config, control, raw code, expected high and low byte
    localparam row_t rows [11] = '{
        '{8'h00, 8'h90, 12'hFFF, 8'h0F, 8'hFF},
        '{8'h00, 8'h91, 12'h800, 8'h80, 8'h00},
        '{8'h80, 8'h90, 12'hFFF, 8'hFF, 8'hFF},
        '{8'h80, 8'h91, 12'hC00, 8'hC0, 8'h00},
        '{8'h80, 8'h84, 12'h400, 8'h04, 8'h00},
        '{8'h00, 8'hC4, 12'h7FF, 8'h07, 8'hFF},
        '{8'h00, 8'h89, 12'h123, 8'h12, 8'h30},
        '{8'h80, 8'h8C, 12'h800, 8'hF8, 8'h00},
        '{8'h00, 8'hD0, 12'h001, 8'h00, 8'h01},
        '{8'h00, 8'hC8, 12'hABC, 8'h0A, 8'hBC},
        '{8'h81, 8'h91, 12'hFFF, 8'hFF, 8'hF0}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic timer2_overflow, timer3_overflow, external_start_pin;
    logic sar_track, sar_convert, sar_powered, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] code, sar_data;
    logic [1:0] ien;
    int num_errors, samples_checked;
    sar_result_format_window_detect sar_result_format_window_detect_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer2_overflow,
        .timer3_overflow, .external_start_pin, .sar_data, .sar_track, .sar_convert,
        .sar_powered, .irq);
    sar_core_model sar_core_model_i (.sar_convert, .sar_powered, .code, .sar_data);
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // the master never assumes the wait count, it loops on pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run(input row_t r, input logic [7:0] expc);
        int n;
        external_start_pin <= 1'b0;
        code <= r.code;
        apb(1'b1, irq_clear_addr, {30'h0, ~r.ctl[1], 1'b1});
        apb(1'b1, cfg_addr, {24'h00_0000, r.cfg});
        // fields first: a start write is decoded with the source and mode already held
        apb(1'b1, ctrl_addr, {24'h00_0000, r.ctl & 8'hEF});
        apb(1'b1, ctrl_addr, {24'h00_0000, r.ctl});
        @(posedge pclk);
        timer3_overflow <= (r.ctl[3:2] == src_timer3);
        timer2_overflow <= (r.ctl[3:2] == src_timer2);
        external_start_pin <= (r.ctl[3:2] == src_pin);
        @(posedge pclk);
        timer3_overflow <= 1'b0;
        timer2_overflow <= 1'b0;
        n = 0;
        rd = '0;
        while (rd[irq_done_bit] !== 1'b1 && n < 40)
        begin
            apb(1'b0, irq_status_addr, '0);
            n++;
        end
        `CHK("status done", 1'b1, rd[irq_done_bit])
        apb(1'b0, ctrl_addr, '0);
        `CHK("control", expc, rd[7:0])
        apb(1'b0, result_high_addr, '0);
        `CHK("result high", r.hi, rd[7:0])
        apb(1'b0, result_low_addr, '0);
        `CHK("result low", r.lo, rd[7:0])
        `CHK("irq", ien[0] | (ien[1] & expc[1]), irq)
        `CHK("track idle", !r.ctl[6], sar_track)
        $display("conversion %h done", r.code);
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, timer2_overflow, timer3_overflow} = '0;
        external_start_pin = 1'b0;
        paddr = '0;
        pwdata = '0;
        code = '0;
        ien = '0;
        num_errors = 0;
        samples_checked = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, ctrl_addr, 32'h0000_0080);
        foreach (rows[i])
            run(rows[i], (rows[i].ctl & 8'hEF) | 8'h20);
        $display("table test done");
        // second reset in mid-run, limits back to their reset values
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ctrl_addr, '0);
        `CHK("control reset", 8'h00, rd[7:0])
        apb(1'b0, upper_limit_low_addr, '0);
        `CHK("upper low reset", 8'hFF, rd[7:0])
        apb(1'b0, upper_limit_high_addr, '0);
        `CHK("upper high reset", 8'hFF, rd[7:0])
        `CHK("irq reset", 1'b0, irq)
        apb(1'b1, upper_limit_low_addr, 32'h0000_005A);
        apb(1'b0, upper_limit_low_addr, '0);
        `CHK("upper low rw", 32'h0000_005A, rd)
        apb(1'b0, 8'h20, '0);
        `CHK("unmapped error", 1'b1, err)
        $display("reset test done");
        apb(1'b1, ctrl_addr, 32'h0000_0080);
        ien = 2'b11;
        apb(1'b1, irq_enable_addr, {30'h0, ien});
        apb(1'b1, upper_limit_high_addr, 32'h0000_0001);
        apb(1'b1, upper_limit_low_addr, 32'h0000_0000);
        run('{8'h00, 8'h90, 12'h200, 8'h02, 8'h00}, 8'hA2);
        run('{8'h00, 8'h92, 12'h050, 8'h00, 8'h50}, 8'hA2);
        apb(1'b1, lower_limit_high_addr, 32'h0000_0003);
        run('{8'h00, 8'h90, 12'h400, 8'h04, 8'h00}, 8'hA0);
        run('{8'h00, 8'h90, 12'h200, 8'h02, 8'h00}, 8'hA2);
        apb(1'b1, irq_clear_addr, 32'h0000_0003);
        apb(1'b1, ctrl_addr, 32'h0000_0080);
        `CHK("irq cleared", 1'b0, irq)
        $display("window test done");
        give_verdict();
    end
endmodule // sar_result_format_window_detect_test

// ===== sar_seq_if.sv
// Purpose: link between the register block and the conversion sequencer
// Assumes: one clock domain
// Notes: raw result is the analog core's code at the end of conversion
`timescale 1ns/1ns
interface sar_seq_if;
    import sar_ctrl_pkg::*;
    logic start;
    logic track_first;
    logic [cfg_div_w-1:0] clk_div;
    logic busy;
    logic done;
    logic converting;
    logic tracking;
    logic [result_w-1:0] sar_data;
    logic [result_w-1:0] result;
    modport ctrl (output start, output track_first, output clk_div, output sar_data,
        input busy, input done, input converting, input tracking, input result);
    modport seq (input start, input track_first, input clk_div, input sar_data,
        output busy, output done, output converting, output tracking, output result);
endinterface

// ===== sar_sequencer.sv
// Purpose: times tracking and conversion with a divided converter clock
// Assumes: start only while idle
// Notes: converter clock period is clk_div+1 system clocks
`timescale 1ns/1ns
module sar_sequencer
    import sar_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    sar_seq_if.seq sif
);
    typedef enum logic [1:0]
    {
        st_idle,
        st_track,
        st_convert
    } seq_state_t;

    typedef struct packed
    {
        seq_state_t state;
        logic [cfg_div_w-1:0] div_cnt;
        logic [sar_cnt_w-1:0] sar_cnt;
        logic done;
        logic [result_w-1:0] result;
    } seq_reg_t;

    seq_reg_t q;
    seq_reg_t d;
    logic tick;

    assign tick = (q.div_cnt == sif.clk_div);
    assign sif.busy = (q.state != st_idle);
    assign sif.done = q.done;
    assign sif.converting = (q.state == st_convert);
    assign sif.tracking = (q.state == st_track);
    assign sif.result = q.result;

    always_comb
    begin
        d = q;
        d.done = 1'b0;
        case (q.state)
            st_idle:
            begin
                d.div_cnt = '0;
                d.sar_cnt = '0;
                if (sif.start)
                begin
                    d.state = sif.track_first ? st_track : st_convert;
                end
            end
            st_track:
            begin
                d.div_cnt = tick ? '0 : q.div_cnt + 1'b1;
                if (tick)
                begin
                    if (q.sar_cnt == sar_cnt_w'(track_sar_clks - 1))
                    begin
                        d.sar_cnt = '0;
                        d.state = st_convert;
                    end
                    else
                    begin
                        d.sar_cnt = q.sar_cnt + 1'b1;
                    end
                end
            end
            st_convert:
            begin
                d.div_cnt = tick ? '0 : q.div_cnt + 1'b1;
                if (tick)
                begin
                    if (q.sar_cnt == sar_cnt_w'(conv_sar_clks - 1))
                    begin
                        d.sar_cnt = '0;
                        d.state = st_idle;
                        d.done = 1'b1;
                        d.result = sif.sar_data;
                    end
                    else
                    begin
                        d.sar_cnt = q.sar_cnt + 1'b1;
                    end
                end
            end
            default:
            begin
                d.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '{state: st_idle, div_cnt: '0, sar_cnt: '0, done: 1'b0, result: '0};
        end
        else
        begin
            q <= d;
        end
    end
endmodule // sar_sequencer
